// ---- hdl/itp_cfg.svh ----
// offsets, field positions, reset values and sizes of the interrupt test block
`ifndef ITP_CFG_SVH
`define ITP_CFG_SVH

// register offsets from the module base
`define ITP_OFF_CTRL      16'h0015
`define ITP_OFF_TEST      16'h0016
`define ITP_OFF_PROMO     16'h001F

// test control field positions
`define ITP_EN_BIT        4
`define ITP_BANK_MSB      3
`define ITP_BANK_LSB      0

// request vector sizes: index i stands for vector low byte 2*i
`define ITP_NUM_REQ       128
`define ITP_NUM_BANK      16
`define ITP_LAST_IMASK    7'h79
`define ITP_EXTERNAL_PIN_NMI_REQUEST_IDX      7'h7A

// top bank only reaches the three lowest force bits
`define ITP_TOP_BANK      4'hF
`define ITP_TOP_MASK      8'h07
`define ITP_FULL_MASK     8'hFF

// reset values
`define ITP_RST_EN        1'h0
`define ITP_RST_BANK      4'h0
`define ITP_RST_FORCE     128'h0
`define ITP_RST_PSEL      7'h79

// defaults of the top-level parameters
`define ITP_IMPL_LO       4'h0
`define ITP_RTI_IDX       7'h78

`endif

// ---- hdl/itp_pkg.sv ----
// types of the interrupt test and priority promotion block
`include "itp_cfg.svh"

package itp_pkg;

  // complete state of the block, registered as one word
  typedef struct packed {
    logic                       en;
    logic [3:0]                 bank;
    logic [`ITP_NUM_REQ-1:0]    frc;
    logic [6:0]                 psel;
    logic [7:0]                 rdata;
    logic [`ITP_NUM_REQ-1:0]    dreq;
    logic                       ipend;
    logic [7:0]                 ivec;
    logic                       xpend;
  } itp_state_t;

endpackage : itp_pkg

// ---- hdl/itp_top.sv ----
// interrupt test override, banked force registers and maskable priority promotion
//
// Our own choice: strobed register access.
`timescale 1ns/10ps
`include "itp_cfg.svh"
module itp_top #(
  parameter logic [3:0] IMPL_LO = `ITP_IMPL_LO,
  parameter logic [6:0] RTI_IDX = `ITP_RTI_IDX
) (
  input  wire  logic                    sys_clk,
  input  wire  logic                    rstn,
  input  wire  logic                    ce,
  input  wire  logic [15:0]             reg_base,
  input  wire  logic [15:0]             reg_addr,
  input  wire  logic [7:0]              reg_wdata,
  input  wire  logic                    reg_wr,
  input  wire  logic                    reg_rd,
  output logic       [7:0]              reg_rdata,
  input  wire  logic                    special_mode,
  input  wire  logic                    cpu_i_mask,
  input  wire  logic                    cpu_x_mask,
  input  wire  logic [`ITP_NUM_REQ-1:0] irq_req_in,
  output logic       [`ITP_NUM_REQ-1:0] dec_req,
  output logic                          imask_pend,
  output logic       [7:0]              imask_vec,
  output logic                          external_pin_nmi_request_pend
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // tick source must be an implemented maskable slot
  if (RTI_IDX > `ITP_LAST_IMASK || RTI_IDX[6:3] < IMPL_LO) begin : g_bad_rti
    $error("tick interrupt index outside implemented maskable range");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // accessible bits of one bank; used by read, write and live masking
  function automatic logic [7:0] bank_mask(input logic [3:0] b);
    logic [7:0] m;
    m = `ITP_FULL_MASK;
    if (b < IMPL_LO) begin
      m = 8'h00;
    end else if (b == `ITP_TOP_BANK) begin
      m = `ITP_TOP_MASK;
    end
    return m;
  endfunction : bank_mask

  localparam itp_pkg::itp_state_t RST_STATE = '{
    en:    `ITP_RST_EN,
    bank:  `ITP_RST_BANK,
    frc:   `ITP_RST_FORCE,
    psel:  `ITP_RST_PSEL,
    rdata: 8'h00,
    dreq:  `ITP_RST_FORCE,
    ipend: 1'b0,
    ivec:  8'h00,
    xpend: 1'b0
  };

  itp_pkg::itp_state_t          s_q;
  itp_pkg::itp_state_t          s_d;
  logic [15:0]                  off;
  logic                         hit_ctrl;
  logic                         hit_test;
  logic                         hit_promo;
  logic [`ITP_NUM_REQ-1:0]      impl_mask;
  logic [`ITP_NUM_REQ-1:0]      live_m;
  logic [`ITP_NUM_REQ-1:0]      feed;
  logic [7:0]                   sel_mask;
  logic [7:0]                   live_slice;
  logic [7:0]                   frc_slice;
  logic                         prom_ok;
  logic [`ITP_NUM_REQ-1:0]      rank;
  logic [6:0]                   best;
  logic                         found;

  // ----------------------------------------------------------------
  // implemented request map
  // ----------------------------------------------------------------
  // one mask byte per bank, so unimplemented slots never reach anyone
  for (genvar b = 0; b < `ITP_NUM_BANK; b++) begin : g_impl
    assign impl_mask[b*8 +: 8] = bank_mask(4'(b));
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // offsets follow the relocated base; wraps harmlessly at the top
  assign off       = reg_addr - reg_base;
  assign hit_ctrl  = (off == `ITP_OFF_CTRL);
  assign hit_test  = (off == `ITP_OFF_TEST);
  assign hit_promo = (off == `ITP_OFF_PROMO);

  // live requests and the decoder source
  assign live_m     = irq_req_in & impl_mask;
  assign feed       = s_q.en ? s_q.frc : live_m;
  assign sel_mask   = bank_mask(s_q.bank);
  assign live_slice = live_m[{s_q.bank, 3'h0} +: 8];
  assign frc_slice  = s_q.frc[{s_q.bank, 3'h0} +: 8];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // register writes, one-cycle read data and the priority decode
  always_comb begin
    s_d   = s_q;
    rank  = '0;
    best  = 7'h00;
    found = 1'b0;
    // read data lives exactly one cycle after the strobe
    s_d.rdata = 8'h00;
    if (reg_rd) begin
      if (hit_ctrl) begin
        s_d.rdata = {3'h0, s_q.en, s_q.bank};
      end else if (hit_test) begin
        if (!special_mode) begin
          s_d.rdata = 8'h00;
        end else if (s_q.en) begin
          s_d.rdata = frc_slice & sel_mask;
        end else begin
          s_d.rdata = live_slice & sel_mask;
        end
      end else if (hit_promo) begin
        s_d.rdata = {s_q.psel, 1'b0};
      end
    end
    // control register: bank always, enable only when fully masked
    if (reg_wr && hit_ctrl) begin
      s_d.bank = reg_wdata[`ITP_BANK_MSB:`ITP_BANK_LSB];
      if (special_mode && cpu_i_mask && cpu_x_mask) begin
        s_d.en = reg_wdata[`ITP_EN_BIT];
        // pending live requests are frozen into the force bits
        if (!s_q.en && reg_wdata[`ITP_EN_BIT]) begin
          s_d.frc = live_m;
        end
      end
    end
    // force bits: bit k of bank b requests vector 16b+2k
    if (reg_wr && hit_test && special_mode && s_q.en && cpu_i_mask) begin
      s_d.frc[{s_q.bank, 3'h0} +: 8] =
        (frc_slice & ~sel_mask) | (reg_wdata & sel_mask);
    end
    // promotion select; bit 0 of the byte is ignored
    if (reg_wr && hit_promo && cpu_i_mask) begin
      s_d.psel = reg_wdata[7:1];
    end
    // promotion is honoured only for implemented maskable slots
    prom_ok = (s_q.psel <= `ITP_LAST_IMASK) && (s_q.psel[6:3] >= IMPL_LO);
    rank = feed;
    rank[`ITP_NUM_REQ-1:`ITP_EXTERNAL_PIN_NMI_REQUEST_IDX] = '0;
    if (prom_ok && s_q.psel != RTI_IDX) begin
      // tick request moves into the promoted source's old slot
      rank[s_q.psel] = feed[RTI_IDX];
      rank[RTI_IDX]  = 1'b0;
    end
    // highest index wins, so F2 sits above F0 down to 00
    for (int i = 0; i <= `ITP_LAST_IMASK; i++) begin
      if (rank[i]) begin
        best  = 7'(i);
        found = 1'b1;
      end
    end
    // the tick only borrows the promoted slot's rank, never its vector
    if (found && prom_ok && s_q.psel != RTI_IDX && best == s_q.psel) begin
      best = RTI_IDX;
    end
    if (prom_ok && feed[s_q.psel]) begin
      best  = s_q.psel;
      found = 1'b1;
    end
    s_d.dreq  = feed;
    s_d.ipend = found;
    s_d.ivec  = found ? {best, 1'b0} : 8'h00;
    s_d.xpend = feed[`ITP_EXTERNAL_PIN_NMI_REQUEST_IDX];
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // clock enable low freezes everything, read data included
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_q <= RST_STATE;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state word
  assign reg_rdata  = s_q.rdata;
  assign dec_req    = s_q.dreq;
  assign imask_pend = s_q.ipend;
  assign imask_vec  = s_q.ivec;
  assign external_pin_nmi_request_pend  = s_q.xpend;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  enable_guard_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && reg_wr && hit_ctrl && !(special_mode && cpu_i_mask && cpu_x_mask)
    |=> s_q.en == $past(s_q.en))
    else $error("override enable changed without special mode and masks");

  enable_take_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && reg_wr && hit_ctrl && special_mode && cpu_i_mask && cpu_x_mask
    |=> s_q.en == $past(reg_wdata[4]))
    else $error("override enable write lost");

  force_block_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && reg_wr && hit_test && !s_q.en |=> s_q.frc == $past(s_q.frc))
    else $error("force bits written with override off");

  force_mask_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && reg_wr && hit_test && !cpu_i_mask |=> s_q.frc == $past(s_q.frc))
    else $error("force bits written with maskable mask clear");

  override_feed_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && s_q.en |=> dec_req == $past(s_q.frc))
    else $error("decoder not fed from force bits");

  pending_kept_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && !s_q.en && reg_wr && hit_ctrl && reg_wdata[4] && special_mode
    && cpu_i_mask && cpu_x_mask |=> s_q.frc == $past(live_m))
    else $error("pending requests lost when override set");

  bank_rw_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && reg_wr && hit_ctrl ##1 ce && reg_rd && hit_ctrl
    |=> reg_rdata[3:0] == $past(reg_wdata[3:0], 2))
    else $error("bank select not read back");

  live_read_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && reg_rd && hit_test && special_mode && !s_q.en
    |=> reg_rdata == $past(live_slice & sel_mask))
    else $error("test read did not show live inputs");

  normal_zero_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && reg_rd && hit_test && !special_mode |=> reg_rdata == 8'h00)
    else $error("test read nonzero in normal mode");

  top_bank_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && reg_rd && hit_test && s_q.bank == 4'hF |=> reg_rdata[7:3] == 5'h00)
    else $error("top bank upper bits read nonzero");

  promo_guard_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && reg_wr && hit_promo && !cpu_i_mask |=> s_q.psel == $past(s_q.psel))
    else $error("promotion written with maskable mask clear");

  promo_win_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && prom_ok && feed[s_q.psel]
    |=> imask_pend && imask_vec == {$past(s_q.psel), 1'b0})
    else $error("active promoted request did not win");

  pin_top_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && !prom_ok && feed[`ITP_LAST_IMASK] |=> imask_vec == 8'hF2)
    else $error("pin request not on top with bad promotion");

  read_once_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data held beyond one cycle");

  reset_clear_a: assert property (
    @(posedge sys_clk)
    !rstn |=> !s_q.en && s_q.bank == 4'h0)
    else $error("override or bank not cleared by reset");

  unimpl_read_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && reg_rd && hit_test && s_q.bank < IMPL_LO |=> reg_rdata == 8'h00)
    else $error("unimplemented bank read nonzero");

  unimpl_write_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && reg_wr && hit_test && s_q.bank < IMPL_LO |=> s_q.frc == $past(s_q.frc))
    else $error("unimplemented bank write changed force bits");

  top_write_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && reg_wr && hit_test && s_q.bank == `ITP_TOP_BANK
    |=> s_q.frc[`ITP_NUM_REQ-1:`ITP_NUM_REQ-5] == 5'h00)
    else $error("top bank force bits above the pin request set");

  force_write_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && reg_wr && hit_test && special_mode && s_q.en && cpu_i_mask
    |=> (frc_slice & sel_mask) == ($past(reg_wdata) & sel_mask))
    else $error("force write did not land in the selected bank");

  force_read_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && reg_rd && hit_test && special_mode && s_q.en
    |=> reg_rdata == $past(frc_slice & sel_mask))
    else $error("test read did not show force bits");

  ctrl_read_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && reg_rd && hit_ctrl
    |=> reg_rdata == {3'h0, $past(s_q.en), $past(s_q.bank)})
    else $error("control read lost enable or bank");

  promo_read_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && reg_rd && hit_promo |=> reg_rdata == {$past(s_q.psel), 1'b0})
    else $error("promotion read did not show select");

  promo_take_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && reg_wr && hit_promo && cpu_i_mask |=> s_q.psel == $past(reg_wdata[7:1]))
    else $error("promotion write lost");

  hold_state_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    !ce |=> s_q == $past(s_q))
    else $error("state moved with clock enable low");

  // ----------------------------------------------------------------
  // decoder checks
  // ----------------------------------------------------------------
  live_feed_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && !s_q.en |=> dec_req == $past(live_m))
    else $error("decoder not fed from live inputs with override off");

  live_cut_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && s_q.en && !reg_wr |=> s_q.frc == $past(s_q.frc))
    else $error("force bits moved without a register write");

  xpin_cut_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && s_q.en && !s_q.frc[`ITP_EXTERNAL_PIN_NMI_REQUEST_IDX] |=> !external_pin_nmi_request_pend)
    else $error("pin request reached decoder under override");

  rank_order_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && !prom_ok && !feed[`ITP_LAST_IMASK] && feed[`ITP_LAST_IMASK - 7'h01]
    |=> imask_vec == 8'hF0)
    else $error("top ranked maskable source not chosen");

  tick_slot_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ce && prom_ok && s_q.psel != RTI_IDX && !feed[s_q.psel]
    |=> !imask_pend || imask_vec != {$past(s_q.psel), 1'b0})
    else $error("idle promoted source reported as winner");

endmodule : itp_top

// ---- verif/itp_cpu_model.sv ----
// cpu core model that takes the winning interrupt vectors
`timescale 1ns/10ps
module itp_cpu_model (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       i_mask,
  input  wire logic       x_mask,
  input  wire logic       imask_pend,
  input  wire logic [7:0] imask_vec,
  input  wire logic       external_pin_nmi_request_pend,
  output logic      [7:0] taken_vec,
  output logic            taken_x
);
  // ---------------------------------------------------------------
  // vector fetch
  // ---------------------------------------------------------------
  // a masked core never fetches, so a vector pending under mask shows up here only after the mask clears
  always @(posedge sys_clk) begin
    if (!rstn) begin
      taken_vec <= 8'h00;
      taken_x   <= 1'b0;
    end else begin
      if (imask_pend && !i_mask) taken_vec <= imask_vec;
      if (external_pin_nmi_request_pend && !x_mask) taken_x <= 1'b1;
    end
  end
endmodule : itp_cpu_model

// ---- verif/interrupt_test_and_priority_promote_test.sv ----
// self-checking bench of the interrupt test and priority promotion block
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got %0h exp %0h", $time, a, e); end end
module interrupt_test_and_priority_promote_test;
  // ---------------------------------------------------------------
  // signals and rows
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] m;
    logic [7:0] wo;
    logic [7:0] wd;
    logic [7:0] ro;
    logic [7:0] ex;
  } itp_row_t;
  logic [15:0]  base = 16'h0800;
  logic         ce = 1'b1;
  logic         sys_clk = 1'b0;
  logic         rstn = 1'b0;
  logic [15:0]  reg_addr = 16'h0000;
  logic [7:0]   reg_wdata = 8'h00;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic [7:0]   reg_rdata;
  logic         special_mode = 1'b0;
  logic         cpu_i_mask = 1'b0;
  logic         cpu_x_mask = 1'b0;
  logic [127:0] irq_req_in = 128'h0;
  logic [127:0] dec_req;
  logic         imask_pend;
  logic [7:0]   imask_vec;
  logic         external_pin_nmi_request_pend;
  logic [7:0]   taken_vec;
  logic         taken_x;
  logic [7:0]   rv;
  int           n_mismatch = 0;
  int           checked = 0;
  int           cycles = 0;
  // mode bits are {special, i mask, x mask}; offset 0x20 is unmapped
  itp_row_t rows [0:17] = '{
    {3'h0, 8'h15, 8'h12, 8'h15, 8'h02}, {3'h3, 8'h20, 8'hFF, 8'h16, 8'h00},
    {3'h4, 8'h20, 8'hFF, 8'h16, 8'h5A}, {3'h6, 8'h15, 8'h12, 8'h15, 8'h02},
    {3'h5, 8'h15, 8'h12, 8'h15, 8'h02}, {3'h7, 8'h16, 8'h33, 8'h16, 8'h5A},
    {3'h7, 8'h15, 8'h12, 8'h15, 8'h12}, {3'h7, 8'h20, 8'h00, 8'h16, 8'h5A},
    {3'h5, 8'h16, 8'hC3, 8'h16, 8'h5A}, {3'h7, 8'h16, 8'hC3, 8'h16, 8'hC3},
    {3'h7, 8'h15, 8'h1F, 8'h16, 8'h05}, {3'h7, 8'h16, 8'hFF, 8'h16, 8'h07},
    {3'h7, 8'h15, 8'h10, 8'h16, 8'h00}, {3'h7, 8'h16, 8'hFF, 8'h16, 8'h00},
    {3'h1, 8'h1F, 8'h20, 8'h1F, 8'hF2}, {3'h2, 8'h1F, 8'h21, 8'h1F, 8'h20},
    {3'h0, 8'h15, 8'h02, 8'h15, 8'h12}, {3'h0, 8'h20, 8'h00, 8'h16, 8'h00}
  };

  itp_top #(.IMPL_LO(4'h1), .RTI_IDX(7'h78)) itp_top_inst (
    .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .reg_base(base),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .special_mode(special_mode), .cpu_i_mask(cpu_i_mask),
    .cpu_x_mask(cpu_x_mask), .irq_req_in(irq_req_in), .dec_req(dec_req),
    .imask_pend(imask_pend), .imask_vec(imask_vec), .external_pin_nmi_request_pend(external_pin_nmi_request_pend)
  );

  itp_cpu_model itp_cpu_model_inst (
    .sys_clk(sys_clk), .rstn(rstn), .i_mask(cpu_i_mask), .x_mask(cpu_x_mask),
    .imask_pend(imask_pend), .imask_vec(imask_vec), .external_pin_nmi_request_pend(external_pin_nmi_request_pend),
    .taken_vec(taken_vec), .taken_x(taken_x)
  );

  // ---------------------------------------------------------------
  // clock, timeout and bus tasks
  // ---------------------------------------------------------------
  always #2 sys_clk = ~sys_clk;

  // whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic test_done();
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // addresses always go out relative to the base
  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= base + {8'h00, off};
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] off, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= base + {8'h00, off};
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // write strobe followed at once by a read of the same register
  task automatic wr_rd(input logic [7:0] off, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    reg_addr  <= base + {8'h00, off};
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge sys_clk);
    reg_rd    <= 1'b0;
    #1 q = reg_rdata;
  endtask : wr_rd

  task automatic settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : settle

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    irq_req_in[23:16]   = 8'h5A;
    irq_req_in[127:120] = 8'hFD;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rd(8'h15, rv);
    `CHK(rv, 8'h00)
    rd(8'h1F, rv);
    `CHK(rv, 8'hF2)
    // table rows: mode, write, read back
    foreach (rows[i]) begin
      @(posedge sys_clk);
      {special_mode, cpu_i_mask, cpu_x_mask} <= rows[i].m;
      wr(rows[i].wo, rows[i].wd);
      rd(rows[i].ro, rv);
      `CHK(rv, rows[i].ex)
    end
    // live lines cut off while forcing; bank F forces F0, F2 and F4
    {special_mode, cpu_i_mask, cpu_x_mask} <= 3'h7;
    irq_req_in <= 128'h0;
    wr(8'h15, 8'h1F);
    wr(8'h16, 8'h07);
    settle();
    `CHK(dec_req[23:16], 8'hC3)
    `CHK(dec_req[127:120], 8'h07)
    `CHK(external_pin_nmi_request_pend, 1'b1)
    `CHK(imask_vec, 8'h20)
    wr(8'h1F, 8'hF4);
    settle();
    `CHK(imask_vec, 8'hF2)
    wr(8'h16, 8'h00);
    settle();
    `CHK(imask_vec, 8'h2E)
    `CHK(external_pin_nmi_request_pend, 1'b0)
    wr(8'h16, 8'h01);
    settle();
    `CHK(imask_vec, 8'hF0)
    // tick alone in a borrowed slot must still give its own vector
    wr(8'h1F, 8'h24);
    wr(8'h15, 8'h12);
    wr(8'h16, 8'h00);
    settle();
    `CHK(imask_vec, 8'hF0)
    cpu_i_mask <= 1'b0;
    settle();
    `CHK(taken_vec, 8'hF0)
    // frozen clock enable drops a write; base moves; write then read with no gap
    ce <= 1'b0;
    wr(8'h15, 8'h03);
    ce <= 1'b1;
    rd(8'h15, rv);
    `CHK(rv, 8'h12)
    base <= 16'h2000;
    rd(8'h15, rv);
    `CHK(rv, 8'h12)
    wr_rd(8'h15, 8'h05, rv);
    `CHK(rv, 8'h15)
    `CHK(taken_x, 1'b1)
    // second reset in mid-run
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rd(8'h15, rv);
    `CHK(rv, 8'h00)
    `CHK(imask_pend, 1'b0)
    test_done();
  end
endmodule : interrupt_test_and_priority_promote_test
